// ===== rtl/toeb_pkg.sv
// Package: register map, field positions, modes and carriers of the timer
package toeb_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CR1 = 8'h00;
  localparam logic [7:0] OFS_CR2 = 8'h04;
  localparam logic [7:0] OFS_SMCR = 8'h08;
  localparam logic [7:0] OFS_DIER = 8'h0c;
  localparam logic [7:0] OFS_SR = 8'h10;
  localparam logic [7:0] OFS_EGR = 8'h14;
  localparam logic [7:0] OFS_CCMR1 = 8'h18;
  localparam logic [7:0] OFS_CCMR2 = 8'h1c;
  localparam logic [7:0] OFS_CCER = 8'h20;
  localparam logic [7:0] OFS_CNT = 8'h24;
  localparam logic [7:0] OFS_PSC = 8'h28;
  localparam logic [7:0] OFS_ARR = 8'h2c;
  localparam logic [7:0] OFS_CCR1 = 8'h34;
  localparam logic [7:0] OFS_CCR4 = 8'h40;
  localparam logic [7:0] OFS_DCR = 8'h48;
  localparam logic [7:0] OFS_DMAR = 8'h4c;

  // ---------------------------------------------------------------
  // Field positions and writable masks
  // ---------------------------------------------------------------
  localparam int CR1_CEN = 0;
  localparam int CR1_OPM = 3;
  localparam int CR1_DIR = 4;
  localparam int CR1_REMAP = 11;
  localparam int CR2_XOR = 7;
  localparam int SMCR_SMS = 0;
  localparam int SMCR_ETP = 15;
  localparam int DIER_UDE = 8;
  localparam int SR_UIF = 0;
  localparam int SR_CC1 = 1;
  localparam int EGR_UG = 0;
  localparam int CCMR_CH_W = 8;
  localparam int CCMR_CE = 7;
  localparam int CCER_CH_W = 4;
  localparam int CCER_E = 0;
  localparam int CCER_P = 1;
  localparam int DCR_DBA = 0;
  localparam int DCR_DBL = 8;
  localparam int CNT_MIRROR = 31;
  localparam int ETR_BIT = 4;
  localparam logic [15:0] CR1_WMASK = 16'h0bff;
  localparam logic [15:0] CR2_WMASK = 16'h0080;
  localparam logic [15:0] SMCR_WMASK = 16'hf00f;
  localparam logic [15:0] DIER_WMASK = 16'h011f;
  localparam logic [15:0] CCMR_WMASK = 16'h8f8f;
  localparam logic [15:0] CCER_WMASK = 16'hbbbb;
  localparam logic [15:0] DCR_WMASK = 16'h1f1f;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [4:0] ONE5 = 5'h01;

  // ---------------------------------------------------------------
  // Slave modes and channel output modes
  // ---------------------------------------------------------------
  localparam logic [3:0] SMS_ENC_A = 4'h1;
  localparam logic [3:0] SMS_ENC_B = 4'h2;
  localparam logic [3:0] SMS_ENC_AB = 4'h3;
  localparam logic [3:0] SMS_RST_TRIG = 4'h8;
  localparam logic [3:0] OC_SET = 4'h1;
  localparam logic [3:0] OC_CLEAR = 4'h2;
  localparam logic [3:0] OC_TOGGLE = 4'h3;
  localparam logic [3:0] OC_FORCE_LO = 4'h4;
  localparam logic [3:0] OC_FORCE_HI = 4'h5;
  localparam logic [3:0] OC_PWM1 = 4'h6;
  localparam logic [3:0] OC_PWM2 = 4'h7;
  localparam logic [3:0] OC_RETRIG1 = 4'h8;
  localparam logic [3:0] OC_RETRIG2 = 4'h9;

  // ---------------------------------------------------------------
  // Carriers and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BURST_IDLE, BURST_REQ, BURST_WAIT} toeb_burst_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } toeb_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } toeb_apb_rsp_s;

  typedef struct packed {
    logic [15:0] cr1, cr2, smcr, dier, sr, ccmr1, ccmr2, ccer;
    logic [15:0] cnt, psc, pcnt, auto_reload_value, dcr;
    logic [3:0][15:0] ccr;
    logic [4:0] sync1, sync2;
    logic fa_prev, fb_prev;
    logic [3:0] pulse, clr, out;
    toeb_burst_e bst;
    logic [4:0] idx;
    logic have;
    logic [31:0] rdata;
    logic err;
  } toeb_state_s;

endpackage

// ===== rtl/toeb_timer.sv
// Timer with retrigger pulse, reference clear, encoder and DMA burst port
//
// Operation
// - Retriggerable pulse goes active on the trigger itself, no delay.
// - A trigger during an active pulse extends that pulse.
// - Clear enable plus high external trigger holds reference low till update.
// - Reference clear acts in compare and PWM modes, never when forced.
// - Slave codes 0001/0010/0011 count edges of input A, B, or both.
// - Edge direction follows the level of the other filtered input.
// - Direction bit updates on every transition of either filtered input.
// - Encoder count wraps within zero and reload; compare keeps working.
// - Mirror enable copies update flag into counter read bit 31 at once.
// - XOR select feeds channel 1 filter with XOR of pins 1 to 3.
// - One update event raises a burst of redirected DMA requests.
// - Five-bit burst length sets the number of transfers per event.
// - Five-bit base gives the first register index counted from control 1.
// - Length 3, base 0xD writes the four compare registers, then restarts.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module toeb_timer
  import toeb_pkg::*;
(
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Register bus
  input wire toeb_apb_req_s apb_req,
  output toeb_apb_rsp_s apb_rsp,
  // Pins
  input wire logic [3:0] ch_in,
  input wire logic etr_in,
  output logic [3:0] ch_out,
  output logic [3:0] ch_oe,
  // DMA request
  output logic dma_req
);

  toeb_state_s s_q, s_d;
  logic ti1, fa, fb, filtered_external_trigger, fa_edge, fb_edge, fa_rise;
  logic enc, trig, step, down, ovf, upd, ug, done, wr, hit_dmar;
  logic forced, ce_bit, refv, pol;
  logic [3:0] slave_mode_select, mode, match;
  logic [31:0] ccmr_all;
  logic [7:0] eaddr;
  logic [4:0] sum;
  logic [32:0] rd;
  logic [15:0] wd;

  // ---------------------------------------------------------------
  // Register read mux: returns {miss, data}
  // ---------------------------------------------------------------
  function automatic logic [32:0] read_word(input logic [7:0] a,
                                            input toeb_state_s st);
    logic [32:0] r;
    r = '0;
    if (a == OFS_CR1) begin
      r[15:0] = st.cr1;
    end else if (a == OFS_CR2) begin
      r[15:0] = st.cr2;
    end else if (a == OFS_SMCR) begin
      r[15:0] = st.smcr;
    end else if (a == OFS_DIER) begin
      r[15:0] = st.dier;
    end else if (a == OFS_SR) begin
      r[15:0] = st.sr;
    end else if (a == OFS_EGR) begin
      r[15:0] = '0;
    end else if (a == OFS_CCMR1) begin
      r[15:0] = st.ccmr1;
    end else if (a == OFS_CCMR2) begin
      r[15:0] = st.ccmr2;
    end else if (a == OFS_CCER) begin
      r[15:0] = st.ccer;
    end else if (a == OFS_CNT) begin
      r[15:0] = st.cnt;
      r[CNT_MIRROR] = st.cr1[CR1_REMAP] & st.sr[SR_UIF];
    end else if (a == OFS_PSC) begin
      r[15:0] = st.psc;
    end else if (a == OFS_ARR) begin
      r[15:0] = st.auto_reload_value;
    end else if (a >= OFS_CCR1 && a <= OFS_CCR4 && a[1:0] == 2'b00) begin
      r[15:0] = st.ccr[2'(8'(a - OFS_CCR1) >> 2)];
    end else if (a == OFS_DCR) begin
      r[15:0] = st.dcr;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ti1 = 1'b0;
    fa = 1'b0;
    fb = 1'b0;
    filtered_external_trigger = 1'b0;
    fa_edge = 1'b0;
    fb_edge = 1'b0;
    fa_rise = 1'b0;
    enc = 1'b0;
    trig = 1'b0;
    step = 1'b0;
    down = s_q.cr1[CR1_DIR];
    ovf = 1'b0;
    upd = 1'b0;
    ug = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    hit_dmar = 1'b0;
    forced = 1'b0;
    ce_bit = 1'b0;
    refv = 1'b0;
    pol = 1'b0;
    slave_mode_select = s_q.smcr[SMCR_SMS +: 4];
    mode = '0;
    match = '0;
    ccmr_all = {s_q.ccmr2, s_q.ccmr1};
    eaddr = apb_req.paddr;
    sum = '0;
    rd = '0;
    wd = apb_req.pwdata[15:0];

    // Pins pass two flops; only the second stage is read below
    s_d.sync1 = {etr_in, ch_in};
    s_d.sync2 = s_q.sync1;

    // Channel 1 may see the XOR of three pins, usable as trigger too
    if (s_q.cr2[CR2_XOR]) begin
      ti1 = ^s_q.sync2[2:0];
    end else begin
      ti1 = s_q.sync2[0];
    end
    fa = ti1 ^ s_q.ccer[CCER_P];
    fb = s_q.sync2[1] ^ s_q.ccer[CCER_CH_W + CCER_P];
    filtered_external_trigger = s_q.sync2[ETR_BIT] ^ s_q.smcr[SMCR_ETP];
    s_d.fa_prev = fa;
    s_d.fb_prev = fb;
    fa_edge = fa ^ s_q.fa_prev;
    fb_edge = fb ^ s_q.fb_prev;
    fa_rise = fa_edge & fa;
    enc = (slave_mode_select == SMS_ENC_A) || (slave_mode_select == SMS_ENC_B) || (slave_mode_select == SMS_ENC_AB);

    // Bus decode; burst window accesses are redirected by base plus index
    hit_dmar = (apb_req.paddr == OFS_DMAR);
    sum = 5'(s_q.dcr[DCR_DBA +: 5] + s_q.idx);
    if (hit_dmar) begin
      eaddr = {1'b0, sum, 2'b00};
    end
    done = apb_req.psel & apb_req.penable & s_q.have;
    wr = done & apb_req.pwrite;
    ug = wr && (eaddr == OFS_EGR) && apb_req.pwdata[EGR_UG];

    // Counter clocking: encoder edges, else the prescaled timer clock
    if (enc) begin
      if (fa_edge) begin
        down = fa ~^ fb;
        step = slave_mode_select[0] & s_q.cr1[CR1_CEN];
        s_d.cr1[CR1_DIR] = down;
      end else if (fb_edge) begin
        down = fa ^ fb;
        step = slave_mode_select[1] & s_q.cr1[CR1_CEN];
        s_d.cr1[CR1_DIR] = down;
      end
    end else if (s_q.cr1[CR1_CEN]) begin
      if (s_q.pcnt == s_q.psc) begin
        s_d.pcnt = '0;
        step = 1'b1;
      end else begin
        s_d.pcnt = 16'(s_q.pcnt + ONE16);
      end
    end

    // Count and wrap inside zero to reload in either direction
    if (step) begin
      if (!down) begin
        if (s_q.cnt == s_q.auto_reload_value) begin
          s_d.cnt = '0;
          ovf = 1'b1;
        end else begin
          s_d.cnt = 16'(s_q.cnt + ONE16);
        end
      end else if (s_q.cnt == '0) begin
        s_d.cnt = s_q.auto_reload_value;
        ovf = 1'b1;
      end else begin
        s_d.cnt = 16'(s_q.cnt - ONE16);
      end
    end
    upd = ovf;
    if (ovf && s_q.cr1[CR1_OPM] && !enc) begin
      s_d.cr1[CR1_CEN] = 1'b0;
    end

    // Reset-plus-trigger: restart counting, also re-arming a pulse
    if (slave_mode_select == SMS_RST_TRIG && fa_rise) begin
      trig = 1'b1;
      s_d.cnt = down ? s_q.auto_reload_value : '0;
      s_d.pcnt = '0;
      s_d.cr1[CR1_CEN] = 1'b1;
    end

    // Software update event reinitialises the counter
    if (ug) begin
      s_d.cnt = down ? s_q.auto_reload_value : '0;
      s_d.pcnt = '0;
      upd = 1'b1;
    end

    // Compare matches only on a counting step, never on a trigger or software update restart
    for (int i = 0; i < 4; i++) begin
      match[i] = step & ~trig & ~ug & (s_d.cnt == s_q.ccr[i]);
    end

    // Channel reference generation and external clear
    for (int i = 0; i < 4; i++) begin
      mode = ccmr_all[CCMR_CH_W * i +: 4];
      ce_bit = ccmr_all[CCMR_CH_W * i + CCMR_CE];
      forced = (mode == OC_FORCE_LO) || (mode == OC_FORCE_HI);
      case (mode)
        OC_SET: begin
          if (match[i]) s_d.pulse[i] = 1'b1;
        end
        OC_CLEAR: begin
          if (match[i]) s_d.pulse[i] = 1'b0;
        end
        OC_TOGGLE: begin
          if (match[i]) s_d.pulse[i] = ~s_q.pulse[i];
        end
        OC_RETRIG1, OC_RETRIG2: begin
          if (trig) begin
            s_d.pulse[i] = 1'b1;
          end else if (match[i]) begin
            s_d.pulse[i] = 1'b0;
          end
        end
        default: begin
          s_d.pulse[i] = s_q.pulse[i];
        end
      endcase
      case (mode)
        OC_FORCE_LO: refv = 1'b0;
        OC_FORCE_HI: refv = 1'b1;
        OC_PWM1: refv = down ? (s_d.cnt <= s_q.ccr[i])
                             : (s_d.cnt < s_q.ccr[i]);
        OC_PWM2: refv = down ? (s_d.cnt > s_q.ccr[i])
                             : (s_d.cnt >= s_q.ccr[i]);
        OC_RETRIG2: refv = ~s_d.pulse[i];
        default: refv = s_d.pulse[i];
      endcase
      // Clear latch survives until update; a high trigger re-sets it
      s_d.clr[i] = (ce_bit & filtered_external_trigger & ~forced)
                   | (s_q.clr[i] & ~upd);
      if (!forced && s_d.clr[i]) begin
        refv = 1'b0;
      end
      pol = s_q.ccer[CCER_CH_W * i + CCER_P];
      s_d.out[i] = refv ^ pol;
    end

    // DMA burst sequencer; one request outstanding at a time
    case (s_q.bst)
      BURST_IDLE: begin
        s_d.idx = '0;
        if (upd && s_q.dier[DIER_UDE]) begin
          s_d.bst = BURST_REQ;
        end
      end
      BURST_REQ: begin
        if (done && hit_dmar) begin
          if (s_q.idx == s_q.dcr[DCR_DBL +: 5]) begin
            s_d.idx = '0;
            s_d.bst = BURST_IDLE;
          end else begin
            s_d.idx = 5'(s_q.idx + ONE5);
            s_d.bst = BURST_WAIT;
          end
        end
      end
      BURST_WAIT: begin
        s_d.bst = BURST_REQ;
      end
      default: begin
        s_d.bst = BURST_IDLE;
      end
    endcase

    // Status flags: a hardware set wins over a write-zero clear
    if (wr && eaddr == OFS_SR) begin
      s_d.sr = s_q.sr & wd;
    end
    s_d.sr[SR_UIF] = s_d.sr[SR_UIF] | upd;
    s_d.sr[SR_CC1 +: 4] = s_d.sr[SR_CC1 +: 4] | match;

    // Software writes land after hardware so they take priority
    if (wr) begin
      if (eaddr == OFS_CR1) begin
        s_d.cr1 = wd & CR1_WMASK;
      end else if (eaddr == OFS_CR2) begin
        s_d.cr2 = wd & CR2_WMASK;
      end else if (eaddr == OFS_SMCR) begin
        s_d.smcr = wd & SMCR_WMASK;
      end else if (eaddr == OFS_DIER) begin
        s_d.dier = wd & DIER_WMASK;
      end else if (eaddr == OFS_CCMR1) begin
        s_d.ccmr1 = wd & CCMR_WMASK;
      end else if (eaddr == OFS_CCMR2) begin
        s_d.ccmr2 = wd & CCMR_WMASK;
      end else if (eaddr == OFS_CCER) begin
        s_d.ccer = wd & CCER_WMASK;
      end else if (eaddr == OFS_CNT) begin
        s_d.cnt = wd;
      end else if (eaddr == OFS_PSC) begin
        s_d.psc = wd;
      end else if (eaddr == OFS_ARR) begin
        s_d.auto_reload_value = wd;
      end else if (eaddr >= OFS_CCR1 && eaddr <= OFS_CCR4
                   && eaddr[1:0] == 2'b00) begin
        s_d.ccr[2'(8'(eaddr - OFS_CCR1) >> 2)] = wd;
      end else if (eaddr == OFS_DCR) begin
        s_d.dcr = wd & DCR_WMASK;
      end
    end

    // Read data is captured once per transfer, in its first clock-enabled cycle with select high
    rd = read_word(eaddr, s_q);
    if (done) begin
      s_d.have = 1'b0;
    end else if (apb_req.psel && !s_q.have) begin
      s_d.have = 1'b1;
      s_d.rdata = rd[31:0];
      s_d.err = rd[32] | (apb_req.pwrite && eaddr == OFS_CNT
                          && 1'b0);
    end
  end

  // ---------------------------------------------------------------
  // State register; clock enable freezes everything
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ready waits for the captured read word, so a frozen setup just stalls
  assign apb_rsp.pready = clk_en & s_q.have;
  assign apb_rsp.prdata = s_q.rdata;
  assign apb_rsp.pslverr = s_q.err & s_q.have & apb_req.psel
                           & apb_req.penable;
  assign dma_req = (s_q.bst == BURST_REQ);
  assign ch_out = s_q.out;

  // Pin drive follows each channel enable bit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_oe[i] = s_q.ccer[CCER_CH_W * i + CCER_E];
    end
  end

endmodule

// ===== tb/toeb_timer_chk.sv
// Checker for bus timing and burst request pacing of the timer
`timescale 1ns/10ps
module toeb_timer_chk
  import toeb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Register bus
  input wire toeb_apb_req_s apb_req,
  input wire toeb_apb_rsp_s apb_rsp,
  // Pins and request
  input wire logic [3:0] ch_in,
  input wire logic etr_in,
  input wire logic [3:0] ch_out,
  input wire logic [3:0] ch_oe,
  input wire logic dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic win;
  // Completed transfer, and completed access to the burst window
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign win = acc && (apb_req.paddr == OFS_DMAR);
  property p_zero_wait;
    apb_req.psel && !apb_req.penable && clk_en ##1
      apb_req.penable && clk_en |-> apb_rsp.pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready late");
  property p_freeze;
    !clk_en |-> !apb_rsp.pready;
  endproperty
  a_freeze: assert property (p_freeze) else $error("pready while frozen");
  property p_unmapped;
    acc && apb_req.paddr == 8'hfc |-> apb_rsp.pslverr && apb_rsp.prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on hole");
  property p_mapped;
    acc && apb_req.paddr == OFS_CR1 |-> !apb_rsp.pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on register");
  property p_win_drop;
    dma_req && win |=> !dma_req;
  endproperty
  a_win_drop: assert property (p_win_drop) else $error("request kept");
  property p_req_hold;
    dma_req && !win |=> dma_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request lost");
  property p_req_gap;
    win |=> !dma_req;
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("no idle cycle");
  property p_fall_cause;
    $fell(dma_req) |-> $past(win);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("stray drop");
  property p_rdata_hold;
    !apb_req.psel |=> $stable(apb_rsp.prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
  property p_oe_hold;
    !(apb_req.psel && apb_req.pwrite) |=> $stable(ch_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
  // Main scenarios reached
  c_win: cover property (win);
  c_drop: cover property ($fell(dma_req));
  c_err: cover property (acc && apb_rsp.pslverr);
endmodule

bind toeb_timer toeb_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp), .ch_in(ch_in),
  .etr_in(etr_in), .ch_out(ch_out), .ch_oe(ch_oe), .dma_req(dma_req));

// ===== tb/toeb_enc_model.sv
// Quadrature encoder model driving the two timer inputs
`timescale 1ns/10ps
module toeb_enc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Step command
  input wire logic step,
  input wire logic dir,
  // Phases, bit 0 is input A
  output logic [1:0] ab
);
  logic [1:0] ph_q;
  // Gray walk; A leads B when moving forward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'h0;
    end else if (step) begin
      ph_q <= dir ? ph_q - 2'h1 : ph_q + 2'h1;
    end
  end
  // One phase changes per step, so the two never switch together
  assign ab = {ph_q[1], ph_q[1] ^ ph_q[0]};
endmodule

// ===== tb/test_toeb_timer.sv
// Self-checking bench: encoder, mirror, clear, retrigger, burst
`timescale 1ns/10ps
module test_toeb_timer
  import toeb_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic etr_in = 1'b0;
  logic x3 = 1'b0;
  logic [31:0] rv;
  logic step = 1'b0;
  logic dir = 1'b0;
  toeb_apb_req_s req = '0;
  toeb_apb_rsp_s rsp;
  logic [3:0] ch_out;
  logic [3:0] ch_oe;
  logic [1:0] ab;
  logic dma_req;
  logic [31:0] rd;
  logic er;
  logic [1:0] ph = 2'h0;
  logic [1:0] o;
  logic [1:0] c;
  logic d;
  logic [15:0] cnt;
  logic [31:0] dat [4];
  logic [4:0] ba;
  logic [4:0] bl;
  int n;
  int err_count = 0;
  int compares = 0;

  // ----------------------------------------
  // Clock, design and encoder
  // ----------------------------------------
  always #4 pclk = ~pclk;
  toeb_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .ch_in({1'b0, x3, ab}), .etr_in(etr_in),
    .ch_out(ch_out), .ch_oe(ch_oe), .dma_req(dma_req));
  toeb_enc_model u_enc (.pclk(pclk), .presetn(presetn), .step(step),
    .dir(dir), .ab(ab));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] fab(input logic [1:0] p);
    return {p[1], p[1] ^ p[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dd);
    int k;
    k = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, dd};
    @(posedge pclk);
    req.penable <= 1'b1;
    // Ready, data and error are all taken at the same rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 200);
    if (rsp.pready !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: pready never came", $time);
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic waitn(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic steps(input int k, input logic dn, input int gap);
    repeat (k) begin
      @(posedge pclk);
      step <= 1'b1;
      dir <= dn;
      @(posedge pclk);
      step <= 1'b0;
      ph = dn ? ph - 2'h1 : ph + 2'h1;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // Forward steps until input A has risen once
  task automatic rise;
    o = fab(ph);
    while (o[0]) begin
      steps(1, 1'b0, 0);
      o = fab(ph);
    end
    do begin
      steps(1, 1'b0, 0);
      o = fab(ph);
    end while (!o[0]);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    finish_test;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(21));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, frozen clock wait, unmapped hole, masked write
    clk_en <= 1'b0;
    fork
      apb(1'b0, OFS_CR1, 32'h0);
      begin
        repeat (4) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    chk(rd, 32'h0);
    chk(32'(ch_oe), 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    rv = $urandom;
    apb(1'b1, OFS_CR2, rv);
    apb(1'b0, OFS_CR2, 32'h0);
    chk(rd, rv & 32'(CR2_WMASK));
    apb(1'b1, OFS_CR2, 32'h0);
    $display("test reset done");
    // Random encoder walk in each counting mode, reload 5
    apb(1'b1, OFS_ARR, 32'h5);
    apb(1'b1, OFS_PSC, 32'h0);
    apb(1'b1, OFS_CCER, 32'h0);
    for (int m = 1; m <= 3; m++) begin
      apb(1'b1, OFS_SMCR, 32'(m));
      apb(1'b1, OFS_CNT, 32'h0);
      apb(1'b1, OFS_CR1, 32'h1);
      cnt = 16'h0;
      repeat (12) begin
        d = 1'($urandom_range(1, 0));
        o = fab(ph);
        steps(1, d, 4);
        c = o ^ fab(ph);
        if ((m[0] && c[0]) || (m[1] && c[1])) begin
          if (d) cnt = (cnt == 16'h0) ? 16'h5 : cnt - 16'h1;
          else cnt = (cnt == 16'h5) ? 16'h0 : cnt + 16'h1;
        end
        apb(1'b0, OFS_CNT, 32'h0);
        chk(rd, {16'h0, cnt});
        apb(1'b0, OFS_CR1, 32'h0);
        chk(32'(rd[CR1_DIR]), 32'(d));
      end
    end
    $display("test encoder done");
    // Update flag mirrored into counter bit 31
    apb(1'b1, OFS_SMCR, 32'h0);
    apb(1'b1, OFS_CR1, 32'h800);
    apb(1'b1, OFS_CNT, 32'h0);
    apb(1'b1, OFS_SR, 32'h0);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_EGR, 32'h1);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd, 32'h8000_0000);
    apb(1'b1, OFS_SR, 32'h0);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd, 32'h0);
    $display("test mirror done");
    // Reference clear in PWM mode, then no effect when forced
    apb(1'b1, OFS_ARR, 32'hffff);
    apb(1'b1, OFS_CCR1, 32'hffff);
    apb(1'b1, OFS_CCMR1, 32'h86);
    apb(1'b1, OFS_CCER, 32'h1);
    apb(1'b1, OFS_CR1, 32'h1);
    waitn(4);
    chk(32'(ch_oe), 32'h1);
    chk(32'(ch_out[0]), 32'h1);
    @(posedge pclk);
    etr_in <= 1'b1;
    waitn(6);
    chk(32'(ch_out[0]), 32'h0);
    @(posedge pclk);
    etr_in <= 1'b0;
    waitn(6);
    chk(32'(ch_out[0]), 32'h0);
    apb(1'b1, OFS_EGR, 32'h1);
    waitn(6);
    chk(32'(ch_out[0]), 32'h1);
    apb(1'b1, OFS_CCMR1, 32'h85);
    @(posedge pclk);
    etr_in <= 1'b1;
    waitn(6);
    chk(32'(ch_out[0]), 32'h1);
    @(posedge pclk);
    etr_in <= 1'b0;
    $display("test clear done");
    // Retriggerable pulse: immediate start, then stretched
    apb(1'b1, OFS_CR1, 32'h0);
    apb(1'b1, OFS_CNT, 32'h0);
    apb(1'b1, OFS_ARR, 32'd40);
    apb(1'b1, OFS_CCR1, 32'h0);
    apb(1'b1, OFS_CCMR1, 32'h08);
    o = fab(ph);
    while (o[0]) begin
      steps(1, 1'b0, 1);
      o = fab(ph);
    end
    apb(1'b1, OFS_SMCR, 32'h8);
    apb(1'b1, OFS_CR1, 32'h8);
    waitn(3);
    chk(32'(ch_out[0]), 32'h0);
    rise;
    waitn(4);
    chk(32'(ch_out[0]), 32'h1);
    waitn(20);
    rise;
    waitn(30);
    chk(32'(ch_out[0]), 32'h1);
    waitn(60);
    chk(32'(ch_out[0]), 32'h0);
    // Third pin reaches channel 1 only through the XOR; here its fall triggers
    apb(1'b1, OFS_CR2, 32'h80);
    @(posedge pclk);
    x3 <= 1'b1;
    waitn(6);
    chk(32'(ch_out[0]), 32'h0);
    @(posedge pclk);
    x3 <= 1'b0;
    waitn(4);
    chk(32'(ch_out[0]), 32'h1);
    apb(1'b1, OFS_CR1, 32'h0);
    apb(1'b1, OFS_CR2, 32'h0);
    apb(1'b1, OFS_SMCR, 32'h0);
    $display("test retrigger done");
    // Bursts: four compares twice, then one transfer to control two
    for (int b = 0; b < 3; b++) begin
      bl = (b == 2) ? 5'h0 : 5'h3;
      ba = (b == 2) ? 5'h1 : 5'hd;
      apb(1'b1, OFS_DCR, {19'h0, bl, 3'h0, ba});
      apb(1'b1, OFS_DIER, 32'h100);
      apb(1'b1, OFS_EGR, 32'h1);
      for (int i = 0; i <= int'(bl); i++) begin
        dat[i] = $urandom;
        n = 0;
        do begin
          @(negedge pclk);
          n++;
        end while (dma_req !== 1'b1 && n < 50);
        chk(32'(dma_req), 32'h1);
        apb(1'b1, OFS_DMAR, dat[i]);
      end
      waitn(4);
      chk(32'(dma_req), 32'h0);
      for (int i = 0; i <= int'(bl); i++) begin
        apb(1'b0, {1'b0, ba + 5'(i), 2'b00}, 32'h0);
        chk(rd, dat[i] & ((b == 2) ? 32'h80 : 32'hffff));
      end
    end
    $display("test burst done");
    finish_test;
  end
endmodule
